/* File: rtl/scd_clock_power.sv */
// clock divider, sync realignment, stabilizer and power-state control
`timescale 1ns/1ns
module scd_clock_power
    import scd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_in_tick,
    input wire logic sync_in,
    input wire logic power_down_pin,
    input wire logic reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire scd_cfg_t cfg,
    input wire logic in_rate_low,
    input wire logic freq_change,
    output logic [7:0] reg_rdata,
    output logic clk_div_out,
    output logic clk_int,
    output logic dcs_active,
    output logic dcs_locked,
    output logic out_oe,
    output scd_pwr_t pwr_en,
    output logic ready
);
    logic [7:0] sync_ctrl_reg;
    logic armed_reg;
    logic [2:0] div_cnt_reg;
    logic [2:0] div_cnt_next;
    logic sync_d_reg;
    logic [15:0] down_cnt_reg;
    logic [15:0] down_cnt_next;
    logic [15:0] relock_cnt_reg;
    scd_pstate_t pstate_reg;
    scd_pstate_t pstate_next;
    logic [12:0] wake_cyc_reg;

    function automatic logic [2:0] scd_half(input logic [2:0] ratio);
        scd_half = {1'b0, ratio[2:1]};
    endfunction

    wire sync_wr = reg_wr && (reg_addr == SCD_SYNC_CTRL_ADDR);
    wire sync_rise = sync_in && !sync_d_reg;
    wire sync_enabled = sync_ctrl_reg[SCD_SYNC_EN_BIT];
    wire first_only = sync_ctrl_reg[SCD_SYNC_FIRST_BIT];
    // first-only mode honors a pulse only while armed
    wire sync_accept = sync_rise && sync_enabled && (!first_only || armed_reg);
    wire down_req = power_down_pin || cfg.pwr_down;
    wire standby_req = cfg.standby && !down_req;
    wire cnt_wrap = (div_cnt_reg == cfg.div_ratio);
    wire run_clk = (pstate_reg == SCD_RUN);
    wire dcs_ok = cfg.dcs_en && !in_rate_low && run_clk;
    wire relock_done = (relock_cnt_reg == 16'h0000);

    always_ff @(posedge mclk)
    begin
        if (srst)
            sync_ctrl_reg <= SCD_SYNC_CTRL_RST;
        else if (sync_wr)
            sync_ctrl_reg <= reg_wdata;
    end

    // set by write wins over clear by a same-cycle sync
    always_ff @(posedge mclk)
    begin
        if (srst)
            armed_reg <= 1'b0;
        else if (sync_wr)
            armed_reg <= 1'b1;
        else if (sync_accept)
            armed_reg <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            sync_d_reg <= 1'b0;
        else
            sync_d_reg <= sync_in;
    end

    // ratio field holds divide minus one, so 0..7 gives 1..8
    always_comb
    begin
        div_cnt_next = div_cnt_reg;
        if (sync_accept)
            div_cnt_next = 3'h0;
        else if (clk_in_tick)
            div_cnt_next = cnt_wrap ? 3'h0 : div_cnt_reg + 3'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            div_cnt_reg <= SCD_DIV_RATIO_RST;
        else
            div_cnt_reg <= div_cnt_next;
    end

    // sampling edge at count zero; stabilizer places falling edge at half
    always_ff @(posedge mclk)
    begin
        if (srst || !run_clk)
            clk_div_out <= 1'b0;
        else if (div_cnt_next == 3'h0 && clk_in_tick)
            clk_div_out <= 1'b1;
        else if (clk_in_tick)
            clk_div_out <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst || !run_clk)
            clk_int <= 1'b0;
        else if (clk_in_tick && div_cnt_next == 3'h0)
            clk_int <= 1'b1;
        else if (clk_in_tick && dcs_ok && div_cnt_next > scd_half(cfg.div_ratio))
            clk_int <= 1'b0;
        else if (clk_in_tick && !dcs_ok)
            clk_int <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            dcs_active <= 1'b0;
        else
            dcs_active <= dcs_ok;
    end

    // worst-case relock wait, so lock is never claimed early
    always_ff @(posedge mclk)
    begin
        if (srst || !dcs_ok || freq_change)
            relock_cnt_reg <= 16'(SCD_RELOCK_CYC);
        else if (!relock_done)
            relock_cnt_reg <= relock_cnt_reg - 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            dcs_locked <= 1'b0;
        else
            dcs_locked <= dcs_ok && relock_done && !freq_change;
    end

    // down time counts up, wake drains it scaled; saturates on long stays
    always_comb
    begin
        pstate_next = pstate_reg;
        down_cnt_next = down_cnt_reg;
        case (pstate_reg)
            SCD_RUN:
            begin
                down_cnt_next = 16'h0000;
                if (down_req || standby_req)
                    pstate_next = SCD_DOWN;
            end
            SCD_DOWN:
            begin
                if (down_cnt_reg != SCD_WAKE_MAX)
                    down_cnt_next = down_cnt_reg + 16'h0001;
                if (!down_req && !standby_req)
                    pstate_next = SCD_WAKE;
            end
            SCD_WAKE:
            begin
                if (down_req || standby_req)
                    pstate_next = SCD_DOWN;
                else if (down_cnt_reg <= 16'(1 << SCD_WAKE_SHIFT))
                    pstate_next = SCD_RUN;
                else
                    down_cnt_next = down_cnt_reg - 16'(1 << SCD_WAKE_SHIFT);
            end
            default:
                pstate_next = SCD_RUN;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            pstate_reg <= SCD_RUN;
        else
            pstate_reg <= pstate_next;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            down_cnt_reg <= 16'h0000;
        else
            down_cnt_reg <= down_cnt_next;
    end

    // longest wake outlasts any delay range, so count its cycles here
    always_ff @(posedge mclk)
    begin
        if (srst || pstate_reg != SCD_WAKE)
            wake_cyc_reg <= 13'h0000;
        else if (wake_cyc_reg != 13'h1fff)
            wake_cyc_reg <= wake_cyc_reg + 13'h0001;
    end

    // standby keeps the reference alive for quicker wake
    always_ff @(posedge mclk)
    begin
        if (srst)
            pwr_en <= '1;
        else
        begin
            pwr_en.ref_on <= pstate_next == SCD_RUN || !down_req;
            pwr_en.refbuf_on <= pstate_next == SCD_RUN;
            pwr_en.bias_on <= pstate_next == SCD_RUN;
            pwr_en.clk_on <= pstate_next == SCD_RUN;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            out_oe <= 1'b1;
        else
            out_oe <= !down_req && pstate_next == SCD_RUN;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            ready <= 1'b1;
        else
            ready <= pstate_next == SCD_RUN;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= {5'h00, armed_reg, sync_ctrl_reg[1:0]};
    end

    // assertions
    sync_restart_a: assert property (@(posedge mclk) disable iff (srst)
        sync_accept |=> div_cnt_reg == 3'h0)
        else $error("divider not restarted by sync");
    first_disarm_a: assert property (@(posedge mclk) disable iff (srst)
        sync_accept && !sync_wr |=> !armed_reg)
        else $error("sync did not disarm");
    first_block_a: assert property (@(posedge mclk) disable iff (srst)
        sync_rise && first_only && !armed_reg && !clk_in_tick && div_cnt_reg != 3'h0
        |=> $stable(div_cnt_reg))
        else $error("unarmed sync changed divider");
    div_wrap_a: assert property (@(posedge mclk) disable iff (srst)
        clk_in_tick && cnt_wrap && !sync_accept |=> div_cnt_reg == 3'h0)
        else $error("divider wrap wrong");
    pin_down_a: assert property (@(posedge mclk) disable iff (srst)
        power_down_pin |=> pstate_reg != SCD_RUN)
        else $error("pin did not power down");
    outputs_hiz_a: assert property (@(posedge mclk) disable iff (srst)
        down_req |=> !out_oe)
        else $error("outputs driven while down");
    full_down_a: assert property (@(posedge mclk) disable iff (srst)
        down_req |=> !pwr_en.ref_on && !pwr_en.clk_on && !pwr_en.bias_on)
        else $error("full power-down left blocks on");
    standby_ref_a: assert property (@(posedge mclk) disable iff (srst)
        standby_req ##1 standby_req |=> pwr_en.ref_on && !pwr_en.clk_on)
        else $error("standby reference wrong");
    dcs_low_a: assert property (@(posedge mclk) disable iff (srst)
        in_rate_low |=> !dcs_active)
        else $error("stabilizer on below limit");
    wake_return_a: assert property (@(posedge mclk) disable iff (srst)
        pstate_reg == SCD_WAKE |-> wake_cyc_reg <= 13'((SCD_WAKE_MAX >> SCD_WAKE_SHIFT) + 16'h0002))
        else $error("no return to normal");
    clk_off_a: assert property (@(posedge mclk) disable iff (srst)
        !run_clk |=> !clk_int && !clk_div_out)
        else $error("clock running while down");
    relock_hold_a: assert property (@(posedge mclk) disable iff (srst)
        freq_change |=> !dcs_locked)
        else $error("lock claimed during frequency change");

    sync_seen_c: cover property (@(posedge mclk) disable iff (srst) sync_accept);
    wake_seen_c: cover property (@(posedge mclk) disable iff (srst)
        pstate_reg == SCD_WAKE ##1 pstate_reg == SCD_RUN);
    lock_seen_c: cover property (@(posedge mclk) disable iff (srst) $rose(dcs_locked));
    sync_block_c: cover property (@(posedge mclk) disable iff (srst)
        sync_rise && first_only && !armed_reg);
    standby_seen_c: cover property (@(posedge mclk) disable iff (srst)
        standby_req ##1 standby_req);
endmodule

/* File: rtl/scd_pkg.sv */
// package: constants and types for the sample clock divider and power control
package scd_pkg;
    localparam logic [8:0] SCD_SYNC_CTRL_ADDR = 9'h109;
    localparam int SCD_SYNC_EN_BIT = 0;
    localparam int SCD_SYNC_FIRST_BIT = 1;
    localparam logic [7:0] SCD_SYNC_CTRL_RST = 8'h00;
    localparam logic [2:0] SCD_DIV_RATIO_RST = 3'h0;
    localparam int SCD_CLK_MHZ = 250;
    localparam int SCD_DCS_MIN_MHZ = 20;
    // stabilizer relock wait, longest figure in ns
    localparam int SCD_RELOCK_NS = 5000;
    localparam int SCD_RELOCK_CYC = SCD_RELOCK_NS * SCD_CLK_MHZ / 1000;
    // wake cycles per power-down cycle: one wake tick per 1 << this (16) down ticks
    localparam int SCD_WAKE_SHIFT = 4;
    localparam logic [15:0] SCD_WAKE_MAX = 16'hffff;

    typedef enum logic [1:0] {
        SCD_RUN = 2'b00,
        SCD_DOWN = 2'b01,
        SCD_WAKE = 2'b11
    } scd_pstate_t;

    typedef struct packed {
        logic pwr_down;
        logic standby;
        logic dcs_en;
        logic [2:0] div_ratio;
    } scd_cfg_t;

    typedef struct packed {
        logic ref_on;
        logic refbuf_on;
        logic bias_on;
        logic clk_on;
    } scd_pwr_t;
endpackage

/* File: test/sample_clock_divider_powerdown_bench.sv */
// self-checking bench for the clock divider and power control
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module sample_clock_divider_powerdown_bench
    import scd_pkg::*;
;
    logic mclk = 0, srst = 1, power_down_pin = 0, reg_wr = 0, in_rate_low = 0;
    logic freq_change = 0, sync_req = 0, clk_in_tick, sync_in, clk_div_out, clk_int;
    logic dcs_active, dcs_locked, out_oe, ready;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rnd = 8'h57;
    logic [3:0] gap = 4'h0;
    scd_cfg_t cfg = '0;
    scd_pwr_t pwr_en;
    int bad_count = 0, check_count = 0, cyc = 0, h, w1, w2;
    always #2 mclk = ~mclk;
    scd_clock_power i_dut (.mclk, .srst, .clk_in_tick, .sync_in, .power_down_pin, .reg_wr,
        .reg_addr, .reg_wdata, .cfg, .in_rate_low, .freq_change, .reg_rdata, .clk_div_out,
        .clk_int, .dcs_active, .dcs_locked, .out_oe, .pwr_en, .ready);
    scd_far_model i_far (.mclk, .gap, .sync_req, .clk_in_tick, .sync_in);
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
        step(2);
    endtask
    task automatic ticks(input int n, output int hi);
        hi = 0;
        repeat (n)
        begin
            do step(1); while (clk_in_tick !== 1'b1);
            if (clk_div_out === 1'b1)
                hi++;
        end
    endtask
    // sync right after a tick so no tick lands before the restart is seen
    // counts ticks from the sync to the next divided edge
    task automatic sync_hit(input int exp);
        int n = 0;
        do step(1); while (!(clk_in_tick === 1'b1 && clk_div_out === 1'b0));
        sync_req = 1'b1;
        step(1);
        sync_req = 1'b0;
        while (!(clk_div_out === 1'b1 && n > 0))
        begin
            if (clk_in_tick === 1'b1)
                n++;
            step(1);
        end
        `CHK("div_restart", exp, n)
    endtask
    task automatic pd(input int d, output int w);
        power_down_pin = 1'b1;
        step(2);
        `CHK("oe_down", 1'b0, out_oe)
        `CHK("pwr_down", 4'h0, pwr_en)
        step(d);
        power_down_pin = 1'b0;
        w = 0;
        do
        begin
            step(1);
            w++;
        end
        while (ready !== 1'b1);
        `CHK("oe_back", 1'b1, out_oe)
    endtask
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        step(12);
        srst = 1'b0;
        step(1);
        `CHK("rst_rdata", 8'h00, reg_rdata)
        `CHK("rst_pwr", 4'hf, pwr_en)
        // first window after a ratio change may hold a stale count
        for (int r = 0; r < 8; r++)
        begin
            rnd = lfsr(rnd);
            gap = rnd[3:0];
            cfg.div_ratio = 3'(r);
            ticks(16, h);
            ticks(3 * (r + 1), h);
            `CHK("div_highs", 3, h)
        end
        gap = 4'hf;
        cfg.div_ratio = 3'h7;
        wr(SCD_SYNC_CTRL_ADDR, 8'h03);
        `CHK("armed", 8'h07, reg_rdata)
        rnd = lfsr(rnd);
        wr({1'b0, rnd}, ~rnd);
        `CHK("unmapped", 8'h07, reg_rdata)
        sync_hit(int'(cfg.div_ratio) + 1);
        // refused pulse lands at count two, so six ticks remain to the wrap
        sync_hit(6);
        `CHK("disarmed", 8'h03, reg_rdata)
        wr(SCD_SYNC_CTRL_ADDR, 8'h01);
        repeat (2) sync_hit(int'(cfg.div_ratio) + 1);
        pd(64 + rnd, w1);
        pd(1600, w2);
        `CHK("wake_grows", 1'b1, w2 > w1)
        cfg.pwr_down = 1'b1;
        step(2);
        `CHK("serial_oe", 1'b0, out_oe)
        cfg.pwr_down = 1'b0;
        do step(1); while (ready !== 1'b1);
        cfg.standby = 1'b1;
        step(2);
        `CHK("standby", 4'h8, pwr_en)
        cfg.standby = 1'b0;
        do step(1); while (ready !== 1'b1);
        gap = 4'h0;
        cfg.dcs_en = 1'b1;
        freq_change = 1'b1;
        step(1);
        freq_change = 1'b0;
        step(3);
        `CHK("dcs_on", 1'b1, dcs_active)
        `CHK("relock_wait", 1'b0, dcs_locked)
        step(SCD_RELOCK_CYC + 10);
        `CHK("relocked", 1'b1, dcs_locked)
        h = 0;
        repeat (32)
        begin
            step(1);
            h += int'(clk_int === 1'b1);
        end
        `CHK("half_high", 16, h)
        in_rate_low = 1'b1;
        step(3);
        `CHK("dcs_slow", 1'b0, dcs_active)
        end_sim();
    end
endmodule

/* File: test/scd_far_model.sv */
// far side model: sample clock source and sync source
`timescale 1ns/1ns
module scd_far_model
(
    input wire logic mclk,
    input wire logic [3:0] gap,
    input wire logic sync_req,
    output logic clk_in_tick,
    output logic sync_in
);
    logic [3:0] cnt_reg;
    initial
    begin
        cnt_reg = 4'h0;
        clk_in_tick = 1'b0;
        sync_in = 1'b0;
    end
    // gap 0 is a prompt source, up to 15 a slow one; sync idles low
    always @(posedge mclk)
    begin
        cnt_reg <= (cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
        clk_in_tick <= (cnt_reg >= gap);
        sync_in <= sync_req;
    end
endmodule
